/* File: cifa_pkg.sv */
// Notes on behaviour
// - Smallest priority value among allowed requests wins
// - Reset uses slot 0; slot n vectors 8n
// - Ext3 and routed watchdog share slot 11
// - OS tick D0/26, data log C8/25
// - Serial0 receive 28/7, transmit 88/8
// - DMA1 48/13, bus fault C0/2
// - Enable bit required to service a request
// - Flag bit stays set until serviced, written with one, or soft reset
// - Debug enables matter only when halted real-time
// - Halted real-time: need debug and normal enable
// - Hardware reset clears flags and all enables
// - Soft reset clears flags, keeps enables
// - Bank0 layout bits 15..9 and 7..2, bits 8 and 1:0 read zero
// - Bank1 layout bits 10..0, 15:11 read zero
// - Vector fetch pulses acknowledge, clears flag
// - Masked source never acknowledged
// - Pins: two falling-edge flops, 1-0-0-0 detect
// - Acknowledge low exactly one clock
package cifa_pkg;
	localparam logic [5:0] OFS_FLAG0    = 6'h00;
	localparam logic [5:0] OFS_EN0      = 6'h04;
	localparam logic [5:0] OFS_DBGFLAG0 = 6'h08;
	localparam logic [5:0] OFS_DBGEN0   = 6'h0C;
	localparam logic [5:0] OFS_FLAG1    = 6'h10;
	localparam logic [5:0] OFS_EN1      = 6'h14;
	localparam logic [5:0] OFS_DBGEN1   = 6'h18;
	localparam logic [5:0] OFS_CTRL     = 6'h1C;
	localparam logic [5:0] OFS_STATUS   = 6'h20;
	localparam logic [15:0] RST_REG16   = 16'h0000;
	localparam int CTRL_ROUTE_BIT       = 0;
	// Bank1 in bits 31:16, bank0 in bits 15:0
	localparam logic [31:0] SRC_VALID   = 32'h07FF_FEFC;
	// Pin positions of external requests 0..4 in the joined flag word
	localparam int PIN_POS [5] = '{2, 16, 3, 11, 19};
	localparam int WDOG_POS             = 11;
	localparam logic [7:0] RESET_VECTOR = 8'h00;
	localparam logic [4:0] RESET_PRIO   = 5'h00;
	// Trap slot per flag bit, index 31 first
	localparam logic [31:0][4:0] SRC_SLOT = {
		5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h1A, 5'h19, 5'h18,
		5'h17, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10,
		5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h00,
		5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h00, 5'h00};
	localparam logic [31:0][4:0] SRC_PRIO = {
		5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1A, 5'h19, 5'h02,
		5'h18, 5'h17, 5'h14, 5'h13, 5'h10, 5'h0C, 5'h08, 5'h04,
		5'h16, 5'h15, 5'h12, 5'h11, 5'h0F, 5'h0E, 5'h0D, 5'h1F,
		5'h0A, 5'h09, 5'h07, 5'h06, 5'h05, 5'h03, 5'h1F, 5'h1F};
	typedef struct packed {
		logic       pending;
		logic [7:0] vector;
		logic [4:0] prio;
	} cifa_sel_s;
endpackage

/* File: cifa_top.sv */
`timescale 1ns/1ps
module cifa_top
	import cifa_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [4:0]  ext_pin,
	input  wire logic [31:0] periph_req,
	input  wire logic        watchdog_request,
	input  wire logic        core_rt_halted,
	input  wire logic        core_soft_reset,
	input  wire logic        core_vector_fetch,
	output cifa_sel_s        irq_sel,
	output logic             irq_acknowledge_out_n
);
	logic [31:0] flag_r;
	logic [31:0] flag_nxt;
	logic [31:0] ien_r;
	logic [31:0] dbien_r;
	logic        route_r;
	logic        reset_pend_r;
	logic [4:0]  sel_idx_r;
	logic        sel_reset_r;
	logic        ack_r;
	logic        ack_n_r;
	logic [31:0] dat_r;
	cifa_sel_s   sel_r;
	logic [4:0]  pin_s0_r;
	logic [4:0]  pin_s1_r;
	logic [4:0]  pin_h0_r;
	logic [4:0]  pin_h1_r;
	logic [4:0]  pin_h2_r;
	logic [4:0]  pin_det_r;
	logic [31:0] set_src;
	logic [31:0] clr_src;
	logic [31:0] eligible;
	logic [31:0] wmask;
	logic        wr_hit;
	logic        fetch_ok;
	logic        best_any;
	logic [4:0]  best_idx;
	logic [4:0]  best_prio;

	// External pins sampled on the falling edge, then pattern match
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_pin
			always_ff @(negedge clock) begin
				if (!nrst) begin
					pin_s0_r[g]  <= 1'b1;
					pin_s1_r[g]  <= 1'b1;
					pin_h0_r[g]  <= 1'b1;
					pin_h1_r[g]  <= 1'b1;
					pin_h2_r[g]  <= 1'b1;
					pin_det_r[g] <= 1'b0;
				end else begin
					pin_s0_r[g]  <= ext_pin[g];
					pin_s1_r[g]  <= pin_s0_r[g];
					pin_h0_r[g]  <= pin_s1_r[g];
					pin_h1_r[g]  <= pin_h0_r[g];
					pin_h2_r[g]  <= pin_h1_r[g];
					pin_det_r[g] <= pin_h2_r[g] & ~pin_h1_r[g] & ~pin_h0_r[g]
						& ~pin_s1_r[g];
				end
			end
		end
	endgenerate

	always_comb begin
		set_src = periph_req;
		for (int i = 0; i < 5; i++) begin
			set_src[PIN_POS[i]] = pin_det_r[i];
		end
		set_src[WDOG_POS] = pin_det_r[3] | (watchdog_request & route_r);
		set_src = set_src & SRC_VALID;
	end

	// Byte-lane write mask for the 16-bit registers
	assign wmask  = {16'h0000, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign fetch_ok = core_vector_fetch & sel_r.pending;

	always_comb begin
		clr_src = 32'h0000_0000;
		if (fetch_ok && !sel_reset_r) begin
			clr_src[sel_idx_r] = 1'b1;
		end
		if (wr_hit && wb_adr_i == OFS_FLAG0) begin
			clr_src[15:0] = clr_src[15:0] | (wb_dat_i[15:0] & wmask[15:0]);
		end
		if (wr_hit && wb_adr_i == OFS_FLAG1) begin
			clr_src[31:16] = clr_src[31:16] | (wb_dat_i[15:0] & wmask[15:0]);
		end
		if (core_soft_reset) begin
			clr_src = 32'hFFFF_FFFF;
		end
		flag_nxt = ((flag_r & ~clr_src) | set_src) & SRC_VALID;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			flag_r <= {RST_REG16, RST_REG16};
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// Enables survive the soft reset
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ien_r   <= {RST_REG16, RST_REG16};
			dbien_r <= {RST_REG16, RST_REG16};
			route_r <= 1'b0;
		end else if (wr_hit) begin
			unique case (wb_adr_i)
				OFS_EN0:    ien_r[15:0] <= ((ien_r[15:0] & ~wmask[15:0])
					| (wb_dat_i[15:0] & wmask[15:0])) & SRC_VALID[15:0];
				OFS_EN1:    ien_r[31:16] <= ((ien_r[31:16] & ~wmask[15:0])
					| (wb_dat_i[15:0] & wmask[15:0])) & SRC_VALID[31:16];
				OFS_DBGEN0: dbien_r[15:0] <= ((dbien_r[15:0] & ~wmask[15:0])
					| (wb_dat_i[15:0] & wmask[15:0])) & SRC_VALID[15:0];
				OFS_DBGEN1: dbien_r[31:16] <= ((dbien_r[31:16] & ~wmask[15:0])
					| (wb_dat_i[15:0] & wmask[15:0])) & SRC_VALID[31:16];
				OFS_CTRL: begin
					if (wb_sel_i[0]) begin
						route_r <= wb_dat_i[CTRL_ROUTE_BIT];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Debug enables gate only while the core is halted in real-time mode
	assign eligible = flag_r & ien_r
		& (core_rt_halted ? dbien_r : 32'hFFFF_FFFF);

	always_comb begin
		best_any  = 1'b0;
		best_idx  = 5'h00;
		best_prio = 5'h1F;
		for (int i = 0; i < 32; i++) begin
			if (eligible[i] && (!best_any || SRC_PRIO[i] < best_prio)) begin
				best_any  = 1'b1;
				best_idx  = 5'(i);
				best_prio = SRC_PRIO[i];
			end
		end
	end

	// Reset takes slot 0 until the core fetches it
	always_ff @(posedge clock) begin
		if (!nrst) begin
			reset_pend_r <= 1'b1;
		end else if (core_soft_reset) begin
			reset_pend_r <= 1'b1;
		end else if (fetch_ok && sel_reset_r) begin
			reset_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			sel_r       <= '{pending: 1'b0, vector: RESET_VECTOR, prio: RESET_PRIO};
			sel_idx_r   <= 5'h00;
			sel_reset_r <= 1'b0;
		end else if (reset_pend_r && !(fetch_ok && sel_reset_r)) begin
			sel_r       <= '{pending: 1'b1, vector: RESET_VECTOR, prio: RESET_PRIO};
			sel_idx_r   <= 5'h00;
			sel_reset_r <= 1'b1;
		end else if (fetch_ok) begin
			// Hold off one cycle so a stale choice is never fetched twice
			sel_r.pending <= 1'b0;
			sel_reset_r   <= 1'b0;
		end else begin
			sel_r.pending <= best_any;
			sel_r.vector  <= {SRC_SLOT[best_idx], 3'b000};
			sel_r.prio    <= best_prio;
			sel_idx_r     <= best_idx;
			sel_reset_r   <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			ack_n_r <= 1'b1;
		end else begin
			ack_n_r <= ~fetch_ok;
		end
	end

	// Wishbone slave: ack one cycle after the request, single beat
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			if (wb_cyc_i && wb_stb_i && !ack_r) begin
				unique case (wb_adr_i)
					OFS_FLAG0:    dat_r <= {16'h0000, flag_r[15:0]};
					OFS_EN0:      dat_r <= {16'h0000, ien_r[15:0]};
					OFS_DBGFLAG0: dat_r <= {16'h0000, flag_r[15:0] & dbien_r[15:0]};
					OFS_DBGEN0:   dat_r <= {16'h0000, dbien_r[15:0]};
					OFS_FLAG1:    dat_r <= {16'h0000, flag_r[31:16]};
					OFS_EN1:      dat_r <= {16'h0000, ien_r[31:16]};
					OFS_DBGEN1:   dat_r <= {16'h0000, dbien_r[31:16]};
					OFS_CTRL:     dat_r <= {31'h0000_0000, route_r};
					OFS_STATUS:   dat_r <= {16'h0000, 3'b000, sel_r.prio,
						sel_idx_r, reset_pend_r, core_rt_halted, sel_r.pending};
					default:      dat_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o              = ack_r;
	assign wb_dat_o              = dat_r;
	assign irq_sel               = sel_r;
	assign irq_acknowledge_out_n = ack_n_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	a_ack_one_low: assert property (!irq_acknowledge_out_n |=> irq_acknowledge_out_n)
		else $error("acknowledge low longer than one clock");
	a_ack_has_cause: assert property ($fell(irq_acknowledge_out_n)
		|-> $past(core_vector_fetch) && $past(sel_r.pending))
		else $error("acknowledge without a pending selection");
	a_flag_fetch_clr: assert property (fetch_ok && !sel_reset_r && !set_src[sel_idx_r]
		&& !core_soft_reset |=> !flag_r[$past(sel_idx_r)])
		else $error("serviced flag not cleared");
	a_hw_reset_zero: assert property (@(posedge clock) disable iff (1'b0)
		!nrst |=> flag_r == 32'h0000_0000 && ien_r == 32'h0000_0000
		&& dbien_r == 32'h0000_0000)
		else $error("hardware reset left state behind");
	a_soft_reset_keep: assert property (core_soft_reset && set_src == 32'h0000_0000
		|=> flag_r == 32'h0000_0000 && $stable(ien_r) && $stable(dbien_r))
		else $error("soft reset effect wrong");
	a_reset_vec_zero: assert property (core_soft_reset ##1 !core_vector_fetch
		|=> sel_r.pending && sel_r.vector == 8'h00 && sel_r.prio == 5'h00)
		else $error("reset vector not presented");
	a_mask_gate_ok: assert property (sel_r.pending && !sel_reset_r
		|-> $past(ien_r[best_idx]) && $past(!core_rt_halted || dbien_r[best_idx]))
		else $error("masked source selected");
	a_vector_table: assert property (sel_r.pending && !sel_reset_r
		|-> sel_r.vector == {SRC_SLOT[sel_idx_r], 3'b000}
		&& sel_r.prio == SRC_PRIO[sel_idx_r])
		else $error("vector or priority mismatch");
	a_wb_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	a_pin_detect_set: assert property (pin_det_r[0] |=> flag_r[PIN_POS[0]])
		else $error("pin request not latched");


	// Reserved positions never hold state
	a_flag_valid_mask: assert property ((flag_r & ~SRC_VALID) == 32'h0000_0000)
		else $error("reserved flag bit set");

	a_en_valid_mask: assert property ((ien_r & ~SRC_VALID) == 32'h0000_0000
		&& (dbien_r & ~SRC_VALID) == 32'h0000_0000)
		else $error("reserved enable bit set");

	a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");

	a_soft_keep_en: assert property (core_soft_reset && !wr_hit
		|=> $stable(ien_r) && $stable(dbien_r))
		else $error("soft reset touched enables");

	a_soft_clear_flag: assert property (core_soft_reset
		|=> (flag_r & ~$past(set_src)) == 32'h0000_0000)
		else $error("soft reset left flags set");

	// A flag rises only from a request and falls only on a clear
	a_flag_no_spurious: assert property ((flag_r & ~$past(flag_r)
		& ~$past(set_src)) == 32'h0000_0000)
		else $error("flag set without request");

	a_flag_hold_pend: assert property (($past(flag_r) & ~flag_r
		& ~$past(clr_src)) == 32'h0000_0000)
		else $error("flag dropped without clear");

	a_set_wins_clear: assert property (set_src != 32'h0000_0000
		|=> (flag_r & $past(set_src)) == $past(set_src))
		else $error("request lost against clear");

	a_sel_idx_valid: assert property (sel_r.pending && !sel_reset_r
		|-> SRC_VALID[sel_idx_r])
		else $error("reserved source selected");

	a_vector_slot8: assert property (sel_r.pending |-> sel_r.vector[2:0] == 3'b000)
		else $error("vector not a multiple of eight");

	a_ack_on_fetch: assert property (fetch_ok |=> !irq_acknowledge_out_n)
		else $error("fetch without acknowledge");

	a_ack_no_fetch: assert property (!fetch_ok |=> irq_acknowledge_out_n)
		else $error("acknowledge without fetch");

	a_sel_drop_fetch: assert property (fetch_ok && !reset_pend_r
		|=> !sel_r.pending)
		else $error("selection held after fetch");

	a_reset_pend_hold: assert property (reset_pend_r && !fetch_ok |=> reset_pend_r)
		else $error("reset slot dropped unfetched");

	a_route_gate: assert property (!route_r && !pin_det_r[3]
		|-> !set_src[WDOG_POS])
		else $error("unrouted watchdog reached slot");

	a_pin_ext3_set: assert property (pin_det_r[3] |=> flag_r[WDOG_POS])
		else $error("pin 3 request not latched");

	a_pin_ext4_set: assert property (pin_det_r[4] |=> flag_r[PIN_POS[4]])
		else $error("pin 4 request not latched");

	a_en_write_lands: assert property (wr_hit && wb_adr_i == OFS_EN0 && wb_sel_i[1:0] == 2'b11
		|=> ien_r[15:0] == ($past(wb_dat_i[15:0]) & SRC_VALID[15:0]))
		else $error("enable write not taken");

	a_wb_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");

	a_wb_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus ack without request");

	c_ack_pulse: cover property ($fell(irq_acknowledge_out_n));
	c_soft_reset_slot: cover property (core_soft_reset ##2 (sel_r.pending && sel_reset_r));
	c_wdog_routed: cover property (watchdog_request && route_r && !pin_det_r[3]);
	c_rt_halted_serve: cover property (core_rt_halted && fetch_ok && !sel_reset_r);
	c_pin_detect: cover property (pin_det_r[3] && route_r);
endmodule

/* File: cifa_core_model.sv */
`timescale 1ns/1ps
module cifa_core_model
	import cifa_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      nrst,
	input  wire logic      run,
	input  wire logic      slow,
	input  wire cifa_sel_s irq_sel,
	input  wire logic      irq_acknowledge_out_n,
	output logic           core_vector_fetch,
	output int             acks,
	output logic           long_low
);
	logic [2:0] wait_r;
	logic       ack_prev_r;
	// One fetch per presented vector; slow mode waits eight cycles
	always_ff @(posedge clock) begin
		if (!nrst || core_vector_fetch || !run || !irq_sel.pending) begin
			core_vector_fetch <= 1'b0;
			wait_r <= 3'h0;
		end else if (!slow || wait_r == 3'h7) begin
			core_vector_fetch <= 1'b1;
		end else begin
			wait_r <= wait_r + 3'h1;
		end
	end
	always_ff @(posedge clock) begin
		if (!nrst) begin
			acks <= 0;
			long_low <= 1'b0;
			ack_prev_r <= 1'b1;
		end else begin
			ack_prev_r <= irq_acknowledge_out_n;
			if (!irq_acknowledge_out_n) acks <= acks + 1;
			if (!irq_acknowledge_out_n && !ack_prev_r) long_low <= 1'b1;
		end
	end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import cifa_pkg::*;
;
	logic        clock = 0, nrst = 0, cyc = 0, we = 0, wdog = 0, halt = 0, srst = 0;
	logic        run = 0, slow = 0, ack, ackn, vf, long_low;
	logic [5:0]  adr = 0;
	logic [3:0]  bsel = 0;
	logic [4:0]  pin = 5'h1F;
	logic [31:0] dat = 0, req = 0, rd, q, m;
	cifa_sel_s   sel;
	int          num_errors, comparisons, acks, b;
	logic [17:0] cs [6] = '{{5'h1A, 8'hD0, 5'h1A}, {5'h19, 8'hC8, 5'h19}, {5'h18, 8'hC0, 5'h02},
		{5'h09, 8'h48, 5'h0D}, {5'h05, 8'h28, 5'h07}, {5'h11, 8'h88, 5'h08}};
	initial begin
		forever #50 clock = ~clock;
	end
	cifa_top dut(.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.ext_pin(pin), .periph_req(req), .watchdog_request(wdog), .core_rt_halted(halt),
		.core_soft_reset(srst), .core_vector_fetch(vf), .irq_sel(sel),
		.irq_acknowledge_out_n(ackn));
	cifa_core_model core(.clock(clock), .nrst(nrst), .run(run), .slow(slow), .irq_sel(sel),
		.irq_acknowledge_out_n(ackn), .core_vector_fetch(vf), .acks(acks), .long_low(long_low));
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		bsel <= 4'h3;
		dat <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 16);
		if (n >= 16) begin
			num_errors++;
			summarize();
		end
		q = rd;
		cyc <= 1'b0;
	endtask
	task fire(input logic [31:0] r, input logic w);
		@(posedge clock);
		req <= r;
		wdog <= w;
		@(posedge clock);
		req <= 32'h0;
		wdog <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	task probe(input logic [31:0] r, input logic w, input logic [7:0] v, input logic [4:0] p);
		fire(r, w);
		chk({18'h0, 1'b1, v, p}, {18'h0, sel});
		wb(1, OFS_FLAG0, 16'hFFFF);
		wb(1, OFS_FLAG1, 16'hFFFF);
	endtask
	function automatic int best(input logic [31:0] r);
		int k;
		k = -1;
		for (int i = 0; i < 32; i++)
			if (r[i] && (k < 0 || SRC_PRIO[i] < SRC_PRIO[k])) k = i;
		return k;
	endfunction
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		summarize();
	end
	initial begin
		void'($urandom(32'hF108EEA9));
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		chk(32'h2000, {18'h0, sel});
		for (int a = 0; a < 28; a += 4) begin
			wb(0, a[5:0], 16'h0000);
			chk(32'h0, q);
		end
		wb(0, 6'h24, 16'h0000);
		chk(32'h0, q);
		run <= 1'b1;
		slow <= 1'b1;
		repeat (14) @(posedge clock);
		chk(1, acks);
		run <= 1'b0;
		wb(1, OFS_EN0, 16'hFFFF);
		wb(0, OFS_EN0, 16'h0000);
		chk(32'hFEFC, q);
		wb(1, OFS_EN1, 16'hFFFF);
		wb(0, OFS_EN1, 16'h0000);
		chk(32'h07FF, q);
		$display("test reset and layout done");
		for (int k = 0; k < 10; k++) begin
			m = $urandom & 32'h07F6F6F0;
			if (m == 0) m = 32'h20;
			b = best(m);
			probe(m, 1'b0, {SRC_SLOT[b], 3'b000}, SRC_PRIO[b]);
		end
		foreach (cs[i]) probe(32'h1 << cs[i][17:13], 1'b0, cs[i][12:5], cs[i][4:0]);
		wb(1, OFS_CTRL, 16'h0000);
		fire(32'h0, 1'b1);
		wb(0, OFS_FLAG0, 16'h0000);
		chk(32'h0, q);
		wb(1, OFS_CTRL, 16'h0001);
		probe(32'h0, 1'b1, 8'h58, 5'h0F);
		$display("test priority done");
		for (int l = 1; l <= 4; l += 3) begin
			@(posedge clock);
			pin[0] <= 1'b0;
			repeat (l) @(posedge clock);
			pin[0] <= 1'b1;
			repeat (4) @(posedge clock);
			wb(0, OFS_FLAG0, 16'h0000);
			chk(l == 4 ? 32'h4 : 32'h0, q);
		end
		wb(1, OFS_FLAG0, 16'hFFFF);
		$display("test pins done");
		wb(1, OFS_EN0, 16'h0000);
		run <= 1'b1;
		slow <= 1'b0;
		fire(32'h20, 1'b0);
		chk(1, acks);
		wb(0, OFS_FLAG0, 16'h0000);
		chk(32'h20, q);
		wb(1, OFS_EN0, 16'hFFFF);
		repeat (6) @(posedge clock);
		chk(2, acks);
		chk(0, long_low);
		wb(0, OFS_FLAG0, 16'h0000);
		chk(32'h0, q);
		run <= 1'b0;
		halt <= 1'b1;
		fire(32'h20, 1'b0);
		chk(32'h0, {31'h0, sel.pending});
		wb(1, OFS_DBGEN0, 16'h0020);
		repeat (2) @(posedge clock);
		chk(32'h1, {31'h0, sel.pending});
		wb(0, OFS_DBGFLAG0, 16'h0000);
		chk(32'h20, q);
		wb(0, OFS_STATUS, 16'h0000);
		chk({19'h0, SRC_PRIO[5], 5'h05, 3'b011}, q);
		halt <= 1'b0;
		wb(1, OFS_DBGEN0, 16'h0000);
		repeat (2) @(posedge clock);
		chk(32'h1, {31'h0, sel.pending});
		$display("test mask and debug done");
		@(posedge clock);
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		wb(0, OFS_FLAG0, 16'h0000);
		chk(32'h0, q);
		wb(0, OFS_EN0, 16'h0000);
		chk(32'hFEFC, q);
		chk(32'h2000, {18'h0, sel});
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		wb(0, OFS_EN0, 16'h0000);
		chk(32'h0, q);
		$display("test resets done");
		summarize();
	end
endmodule
